// ===== hw/nao_arith.v
// Arithmetic instruction unit of a 4-bit core: add, inc, dec, reverse sub
`timescale 1ns/10ps
`include "nao_defines.vh"
module nao_arith (
  // Clock and reset
  input  wire       MCLK,
  input  wire       RSTN,
  // Instruction byte stream, one byte per strobe
  input  wire       OP_VALID,
  input  wire [7:0] OP_BYTE,
  // Architectural state
  output reg  [3:0] ACC,
  output reg  [3:0] HIGH_PTR,
  output reg  [3:0] LOW_PTR,
  output reg        CARRY,
  output reg        ZERO,
  output reg        STATUS,
  // Status of the sequencer
  output reg        BUSY,
  output reg        DONE
);
  ////////////////////////////////////////////////////////////////////////
  // States
  localparam ST_FETCH  = 4'b0001;
  localparam ST_SECOND = 4'b0010;
  localparam ST_READ   = 4'b0100;
  localparam ST_EXEC   = 4'b1000;

  // Operation classes latched from the opcode
  localparam K_INC_MEM = 4'd0;
  localparam K_DEC_ACC = 4'd1;
  localparam K_DEC_LOW = 4'd2;
  localparam K_ADD_MEM = 4'd3;
  localparam K_REVERSE_SUBTRACT_CARRY_OP   = 4'd4;
  localparam K_ADD_HI  = 4'd5;
  localparam K_ADD_LO  = 4'd6;
  localparam K_ADDI_M  = 4'd7;
  localparam K_REVERSE_SUBTRACT_OP_A  = 4'd8;
  localparam K_ADD_PG0 = 4'd9;
  localparam K_NONE    = 4'd15;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] kind;
  reg [3:0] next_kind;
  reg [3:0] imm;
  reg [3:0] next_imm;
  reg [7:0] addr;
  reg [7:0] next_addr;
  reg       prefixed;
  reg       next_prefixed;

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  wire [3:0] mem_q;
  reg  [3:0] opa;
  reg  [3:0] opb;
  reg        cin;
  wire [3:0] sum;
  wire       cout;
  reg        wr_en;

  // Subtraction done as a + ~b + 1, or a + ~b + CARRY for the carry form, so cout is not-borrow
  always @* begin
    opa = `NAO_NIB_ZERO;
    opb = `NAO_NIB_ZERO;
    cin = 1'b0;
    case (kind)
      K_INC_MEM: begin
        opa = mem_q;
        opb = `NAO_ONE;
      end
      K_DEC_ACC: begin
        opa = ACC;
        opb = ~`NAO_ONE;
        cin = 1'b1;
      end
      K_DEC_LOW: begin
        opa = LOW_PTR;
        opb = ~`NAO_ONE;
        cin = 1'b1;
      end
      K_ADD_MEM: begin
        opa = ACC;
        opb = mem_q;
      end
      K_REVERSE_SUBTRACT_CARRY_OP: begin
        opa = mem_q;
        opb = ~ACC;
        cin = CARRY;
      end
      K_ADD_HI: begin
        opa = HIGH_PTR;
        opb = imm;
      end
      K_ADD_LO: begin
        opa = LOW_PTR;
        opb = imm;
      end
      K_ADDI_M: begin
        opa = mem_q;
        opb = imm;
      end
      K_REVERSE_SUBTRACT_OP_A: begin
        opa = imm;
        opb = ~ACC;
        cin = 1'b1;
      end
      K_ADD_PG0: begin
        opa = mem_q;
        opb = imm;
      end
      default: begin opa = `NAO_NIB_ZERO; end
    endcase
  end

  nao_adder u_adder (
    .a    (opa),
    .b    (opb),
    .cin  (cin),
    .sum  (sum),
    .cout (cout)
  );

  // Memory is read one cycle ahead of use through the registered port
  nao_mem u_mem (
    .clk     (MCLK),
    .rd_addr (addr),
    .rd_data (mem_q),
    .wr_en   (wr_en),
    .wr_addr (addr),
    .wr_data (sum)
  );

  always @* begin
    wr_en = 1'b0;
    if (state == ST_EXEC) begin
      wr_en = (kind == K_INC_MEM) || (kind == K_ADDI_M) ||
              (kind == K_ADD_PG0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode and sequencing
  function [3:0] sub_kind;
    input [3:0] hi;
    begin
      case (hi)
        `NAO_SUB_ADD_HIGH: sub_kind = K_ADD_HI;
        `NAO_SUB_ADD_LOW:  sub_kind = K_ADD_LO;
        `NAO_SUB_ADD_MEM:  sub_kind = K_ADDI_M;
        `NAO_SUB_REVERSE_SUBTRACT_OP_ACC: sub_kind = K_REVERSE_SUBTRACT_OP_A;
        default:           sub_kind = K_NONE;
      endcase
    end
  endfunction

  function needs_mem;
    input [3:0] k;
    begin
      needs_mem = (k == K_INC_MEM) || (k == K_ADD_MEM) ||
                  (k == K_REVERSE_SUBTRACT_CARRY_OP) || (k == K_ADDI_M) ||
                  (k == K_ADD_PG0);
    end
  endfunction

  // Next-state logic; memory forms take one extra read cycle
  always @* begin
    next_state    = state;
    next_kind     = kind;
    next_imm      = imm;
    next_addr     = {HIGH_PTR, LOW_PTR};
    next_prefixed = prefixed;
    case (state)
      ST_FETCH: begin
        next_prefixed = 1'b0;
        if (OP_VALID) begin
          next_state = ST_EXEC;
          case (OP_BYTE)
            `NAO_OP_INC_MEM:   next_kind = K_INC_MEM;
            `NAO_OP_DEC_ACC:   next_kind = K_DEC_ACC;
            `NAO_OP_DEC_LOW:   next_kind = K_DEC_LOW;
            `NAO_OP_ADD_MEM:   next_kind = K_ADD_MEM;
            `NAO_OP_REVERSE_SUBTRACT_CARRY_OP_MEM: next_kind = K_REVERSE_SUBTRACT_CARRY_OP;
            `NAO_OP_PREFIX: begin
              next_kind     = K_NONE;
              next_prefixed = 1'b1;
              next_state    = ST_SECOND;
            end
            `NAO_OP_ADD_PAGE0: begin
              next_kind  = K_ADD_PG0;
              next_state = ST_SECOND;
            end
            default: begin
              next_kind  = K_NONE;
              next_state = ST_FETCH;
            end
          endcase
          if (next_state == ST_EXEC && needs_mem(next_kind)) begin
            next_state = ST_READ;
          end
        end
      end
      ST_SECOND: begin
        if (OP_VALID) begin
          if (prefixed) begin
            next_kind = sub_kind(OP_BYTE[7:4]);
            next_imm  = OP_BYTE[3:0];
          end else begin
            next_imm  = OP_BYTE[7:4];
            next_addr = {`NAO_NIB_ZERO, OP_BYTE[3:0]};
          end
          next_state = needs_mem(next_kind) ? ST_READ : ST_EXEC;
          if (next_kind == K_NONE) begin
            next_state = ST_FETCH;
          end
        end
      end
      ST_READ:  begin
        next_addr  = addr;
        next_state = ST_EXEC;
      end
      ST_EXEC:  begin
        next_addr  = addr;
        next_state = ST_FETCH;
      end
      default:  next_state = ST_FETCH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags
  always @(posedge MCLK) begin
    if (!RSTN) begin
      state    <= ST_FETCH;
      kind     <= K_NONE;
      imm      <= `NAO_NIB_ZERO;
      addr     <= {`NAO_NIB_ZERO, `NAO_NIB_ZERO};
      prefixed <= 1'b0;
      ACC      <= `NAO_NIB_ZERO;
      HIGH_PTR <= `NAO_NIB_ZERO;
      LOW_PTR  <= `NAO_NIB_ZERO;
      CARRY    <= 1'b0;
      ZERO     <= 1'b0;
      STATUS   <= 1'b0;
      BUSY     <= 1'b0;
      DONE     <= 1'b0;
    end else begin
      state    <= next_state;
      kind     <= next_kind;
      imm      <= next_imm;
      addr     <= next_addr;
      prefixed <= next_prefixed;
      BUSY     <= (next_state != ST_FETCH);
      DONE     <= (state == ST_EXEC);
      if (state == ST_EXEC) begin
        // Zero flag always from the 4-bit result
        ZERO <= (sum == `NAO_NIB_ZERO);
        case (kind)
          K_DEC_ACC, K_REVERSE_SUBTRACT_OP_A: begin
            ACC    <= sum;
            STATUS <= cout;
          end
          K_ADD_MEM: begin
            ACC    <= sum;
            STATUS <= cout;
          end
          K_REVERSE_SUBTRACT_CARRY_OP: begin
            ACC    <= sum;
            CARRY  <= cout;
            STATUS <= cout;
          end
          K_DEC_LOW: begin
            LOW_PTR <= sum;
            STATUS  <= cout;
          end
          K_ADD_LO: begin
            LOW_PTR <= sum;
            STATUS  <= ~cout;
          end
          K_ADD_HI: begin
            HIGH_PTR <= sum;
            STATUS   <= ~cout;
          end
          K_INC_MEM, K_ADDI_M, K_ADD_PG0: begin
            STATUS <= ~cout;
          end
          default: ZERO <= ZERO;
        endcase
      end
    end
  end
endmodule // nao_arith

// ===== hw/nao_defines.vh
// Opcode, field and size constants for the nibble arithmetic unit
`ifndef NAO_DEFINES_VH
`define NAO_DEFINES_VH
`define NAO_OP_INC_MEM    8'h0a
`define NAO_OP_DEC_ACC    8'h09
`define NAO_OP_DEC_LOW    8'h19
`define NAO_OP_ADD_MEM    8'h17
`define NAO_OP_REVERSE_SUBTRACT_CARRY_OP_MEM  8'h14
`define NAO_OP_PREFIX     8'h38
`define NAO_OP_ADD_PAGE0  8'h2f
`define NAO_SUB_ADD_HIGH  4'hc
`define NAO_SUB_ADD_LOW   4'h8
`define NAO_SUB_ADD_MEM   4'h4
`define NAO_SUB_REVERSE_SUBTRACT_OP_ACC  4'h1
`define NAO_NIB_ZERO      4'h0
`define NAO_ONE           4'h1
`define NAO_ADDR_W        8
`define NAO_MEM_DEPTH     256
`endif

// ===== hw/nao_mem.v
// Data memory of 4-bit nibbles with registered read data
`timescale 1ns/10ps
module nao_mem (
  // Clock
  input  wire       clk,
  // Read port
  input  wire [7:0] rd_addr,
  output reg  [3:0] rd_data,
  // Write port
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [3:0] wr_data
);
  reg [3:0] mem [0:255];

  // Read first (old data on a same-address write), read registered; no reset so it maps to RAM
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // nao_mem

// ===== hw/nao_adder.v
// 4-bit adder with carry in and carry out of bit 3
`timescale 1ns/10ps
module nao_adder (
  // Operands
  input  wire [3:0] a,
  input  wire [3:0] b,
  input  wire       cin,
  // Result
  output wire [3:0] sum,
  output wire       cout
);
  wire [4:0] full;

  // Sum kept to four bits, overflow goes to cout
  assign full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  assign sum  = full[3:0];
  assign cout = full[4];
endmodule // nao_adder

// ===== sim/nao_arith_props.sv
// Port assertions for the nibble arithmetic unit
`timescale 1ns/10ps
module nao_arith_props (
  // Clock and reset
  input logic       MCLK,
  input logic       RSTN,
  // Instruction stream
  input logic       OP_VALID,
  input logic [7:0] OP_BYTE,
  // State and status
  input logic [3:0] ACC,
  input logic [3:0] HIGH_PTR,
  input logic [3:0] LOW_PTR,
  input logic       CARRY,
  input logic       ZERO,
  input logic       STATUS,
  input logic       BUSY,
  input logic       DONE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Opcode accepted only while idle
  wire tk = !BUSY && OP_VALID;
  // Prefix then a second byte of the given kind
  sequence s_pre(n);
    tk && OP_BYTE == 8'h38 ##1 OP_VALID && OP_BYTE[7:4] == n;
  endsequence
  ////////////////////////////////
  property p_dec_acc;
    tk && OP_BYTE == 8'h09 |-> ##2 DONE && ACC == $past(ACC, 2) - 4'h1
      && CARRY == $past(CARRY, 2) && STATUS == ($past(ACC, 2) != 4'h0);
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("acc decrement");
  property p_dec_low;
    tk && OP_BYTE == 8'h19 |-> ##2 LOW_PTR == $past(LOW_PTR, 2) - 4'h1
      && STATUS == ($past(LOW_PTR, 2) != 4'h0) && ZERO == (LOW_PTR == 4'h0);
  endproperty
  a_dec_low: assert property (p_dec_low) else $error("low decrement");
  property p_add_high;
    s_pre(4'hc) |-> ##2 DONE
      && HIGH_PTR == $past(HIGH_PTR, 3) + $past(OP_BYTE[3:0], 2);
  endproperty
  a_add_high: assert property (p_add_high) else $error("high add");
  property p_add_low;
    s_pre(4'h8) |-> ##2 LOW_PTR == $past(LOW_PTR, 3) + $past(OP_BYTE[3:0], 2)
      && STATUS == ({1'b0, $past(LOW_PTR, 3)} + $past(OP_BYTE[3:0], 2) < 5'h10);
  endproperty
  a_add_low: assert property (p_add_low) else $error("low add");
  property p_reverse_subtract_op;
    s_pre(4'h1) |-> ##2 ACC == $past(OP_BYTE[3:0], 2) - $past(ACC, 3)
      && STATUS == ($past(OP_BYTE[3:0], 2) >= $past(ACC, 3));
  endproperty
  a_reverse_subtract_op: assert property (p_reverse_subtract_op) else $error("reverse subtract");
  property p_inc_mem;
    tk && OP_BYTE == 8'h0a |-> ##1 !DONE ##1 !DONE ##1 DONE
      && CARRY == $past(CARRY, 3);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("mem increment");
  property p_page0;
    tk && OP_BYTE == 8'h2f ##1 OP_VALID |-> ##3 DONE && ACC == $past(ACC, 4);
  endproperty
  a_page0: assert property (p_page0) else $error("page0 add");
  property p_add_mem;
    tk && OP_BYTE == 8'h17 |-> ##3 DONE && CARRY == $past(CARRY, 3)
      && ZERO == (ACC == 4'h0);
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("mem add");
  property p_reverse_subtract_carry_op;
    tk && OP_BYTE == 8'h14 |-> ##3 DONE && STATUS == CARRY
      && ZERO == (ACC == 4'h0);
  endproperty
  a_reverse_subtract_carry_op: assert property (p_reverse_subtract_carry_op) else $error("carry subtract");
  property p_done;
    DONE |=> !DONE;
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_busy;
    tk && OP_BYTE == 8'h09 |=> BUSY ##1 !BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy span");
  // Main scenarios reached
  c_reverse_subtract_op: cover property (s_pre(4'h1));
  c_high: cover property (s_pre(4'hc));
  c_page0: cover property (tk && OP_BYTE == 8'h2f);
endmodule // nao_arith_props
bind nao_arith nao_arith_props chk_u (.MCLK, .RSTN, .OP_VALID, .OP_BYTE,
  .ACC, .HIGH_PTR, .LOW_PTR, .CARRY, .ZERO, .STATUS, .BUSY, .DONE);

// ===== sim/nao_arith_bench.sv
// Self-checking bench for the nibble arithmetic unit
`timescale 1ns/10ps
`define CHK(nm, e, s) begin check_count = check_count + 1; \
  if ((s) !== (e)) begin n_fail = n_fail + 1; \
  $display("ERROR %s exp %h seen %h", nm, e, s); end end
module nao_arith_bench;
  // Driven and observed ports
  reg        MCLK = 1'b0;
  reg        RSTN = 1'b0;
  reg        OP_VALID = 1'b0;
  reg  [7:0] OP_BYTE = 8'h00;
  wire [3:0] ACC, HIGH_PTR, LOW_PTR;
  wire       CARRY, ZERO, STATUS, BUSY, DONE;
  integer    n_fail = 0;
  integer    check_count = 0;
  reg        exp_carry = 1'b0;
  // 100 ns period
  always #50 MCLK = ~MCLK;
  nao_arith dut_u (.MCLK, .RSTN, .OP_VALID, .OP_BYTE, .ACC, .HIGH_PTR,
    .LOW_PTR, .CARRY, .ZERO, .STATUS, .BUSY, .DONE);
  ////////////////////////////////
  // Verdict and end of run
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // One instruction, bounded wait for its done pulse
  task run(input [7:0] b0, input [7:0] b1, input two, input integer lat);
    integer n;
    begin
      OP_VALID = 1'b1;
      OP_BYTE = b0;
      @(posedge MCLK) #1;
      if (two) begin
        OP_BYTE = b1;
        @(posedge MCLK) #1;
      end
      OP_VALID = 1'b0;
      n = 1 + two;
      while (DONE !== 1'b1 && n < 20) begin
        @(posedge MCLK) #1;
        n = n + 1;
      end
      `CHK("latency", lat, n)
      `CHK("busy", 1'b0, BUSY)
      if (n >= 20) tally_and_finish;
    end
  endtask
  // Whole state; zero and status checks skipped when their expected value is x, carry always checked
  task st(input [3:0] a, l, h, input z, s);
    begin
      `CHK("acc", a, ACC)
      `CHK("low", l, LOW_PTR)
      `CHK("high", h, HIGH_PTR)
      `CHK("carry", exp_carry, CARRY)
      if (z !== 1'bx) `CHK("zero", z, ZERO)
      if (s !== 1'bx) `CHK("status", s, STATUS)
    end
  endtask
  ////////////////////////////////
  // Decrements wrap from zero with borrow
  task t_dec;
    begin
      run(8'h09, 8'h00, 1'b0, 2);
      st(4'hf, 4'h0, 4'h0, 1'b0, 1'b0);
      run(8'h19, 8'h00, 1'b0, 2);
      st(4'hf, 4'hf, 4'h0, 1'b0, 1'b0);
    end
  endtask
  // Complements and a zero result
  task t_reverse_subtract_op;
    begin
      run(8'h38, 8'h10, 1'b1, 3);
      st(4'h1, 4'hf, 4'h0, 1'b0, 1'b0);
      run(8'h38, 8'h1f, 1'b1, 3);
      st(4'he, 4'hf, 4'h0, 1'b0, 1'b1);
      run(8'h38, 8'h1e, 1'b1, 3);
      st(4'h0, 4'hf, 4'h0, 1'b1, 1'b1);
    end
  endtask
  // Pointer adds, increment and decrement forms
  task t_ptr;
    begin
      run(8'h38, 8'h81, 1'b1, 3);
      st(4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
      run(8'h38, 8'hc1, 1'b1, 3);
      st(4'h0, 4'h0, 4'h1, 1'b0, 1'b1);
      run(8'h38, 8'hcf, 1'b1, 3);
      st(4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
    end
  endtask
  // Unknown opcode leaves everything alone
  task t_refuse;
    integer i;
    begin
      OP_VALID = 1'b1;
      OP_BYTE = 8'hff;
      @(posedge MCLK) #1;
      // Prefix with a subcode outside this unit
      OP_BYTE = 8'h38;
      @(posedge MCLK) #1;
      OP_BYTE = 8'h50;
      @(posedge MCLK) #1;
      OP_VALID = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        `CHK("no done", 1'b0, DONE)
        @(posedge MCLK) #1;
      end
      `CHK("idle", 1'b0, BUSY)
      st(4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
    end
  endtask
  // Memory forms; no load path, so nibbles are preloaded by backdoor
  task t_mem;
    begin
      dut_u.u_mem.mem[8'h00] = 4'h9;
      dut_u.u_mem.mem[8'h03] = 4'h5;
      run(8'h0a, 8'h00, 1'b0, 3);
      st(4'h0, 4'h0, 4'h0, 1'b0, 1'b1);
      run(8'h38, 8'h46, 1'b1, 4);
      st(4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
      run(8'h2f, 8'h13, 1'b1, 4);
      st(4'h0, 4'h0, 4'h0, 1'b0, 1'b1);
      run(8'h38, 8'h83, 1'b1, 3);
      run(8'h17, 8'h00, 1'b0, 3);
      st(4'h6, 4'h3, 4'h0, 1'b0, 1'b0);
      run(8'h09, 8'h00, 1'b0, 2);
      run(8'h14, 8'h00, 1'b0, 3);
      exp_carry = 1'b1;
      st(4'h0, 4'h3, 4'h0, 1'b1, 1'b1);
      run(8'h14, 8'h00, 1'b0, 3);
      st(4'h6, 4'h3, 4'h0, 1'b0, 1'b1);
    end
  endtask
  // Reset, then each scenario back to back
  initial begin
    repeat (3) @(posedge MCLK);
    #1 RSTN = 1'b1;
    st(4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    t_dec;
    t_reverse_subtract_op;
    t_ptr;
    t_refuse;
    t_mem;
    tally_and_finish;
  end
endmodule // nao_arith_bench
